/* src/isc_defs.svh */
// Purpose: constants for the interrupt status collector
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   definitions only
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
`define ISC_OFS_STATUS    12'h600
`define ISC_OFS_CONTROL   12'h604
`define ISC_STATUS_RESET  32'h0000_0C00
`define ISC_CONTROL_RESET 32'h0000_0000
// latched flags: 31..16, 15, 14, 12, 3..0
`define ISC_LATCH_MASK    32'hFFFF_D00F
// level flags: 13, 11, 10, 9, 8
`define ISC_LEVEL_MASK    32'h0000_2F00
// enable bits that software may write (13 is a mirror)
`define ISC_CTL_WR_MASK   32'hFFFF_DF00
`define ISC_BIT_MDP       5'd29
`define ISC_BIT_OPNE      5'd13
`define ISC_BIT_IPN       5'd12
`define ISC_BIT_IFE       5'd11
`define ISC_BIT_OFE       5'd10
`define ISC_BIT_IPF       5'd9
`define ISC_BIT_OFF       5'd8
`define ISC_SOFT_LSB      0
`define ISC_SOFT_W        4
`endif

/* src/isc_pkg.sv */
// Purpose: types for the interrupt status collector
// Assumes: none
// Notes:   queue levels travel as one struct
package isc_pkg;
   typedef struct packed {
      logic outbound_post_not_empty;
      logic inbound_free_empty;
      logic outbound_free_empty;
      logic inbound_post_full;
      logic outbound_free_full;
   } isc_queue_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } isc_req_t;
endpackage : isc_pkg

/* src/isc_collector.sv */
// Purpose: interrupt status register with enable control and mapped output
// Assumes: register port synchronous to mclk, events are one-cycle-or-longer levels
// Notes:   flags latch on the rising edge of each condition, the new-entry flag on its enabled level
// Operation
// R1: bits 31..24 hold error-log, parity, config-status and four dma flags
// R2: bits 23..16 hold mapped interrupt inputs and mailbox 3..0 flags
// R3: bits 15..8 hold parity, power, and message-queue flags
// R4: soft interrupt flags in bits 3..0; bits 7..4 reserved, read zero
// R5: a latched flag sets when its condition becomes asserted
// R6: latched flag stays set until one is written to it
// R7: clearing a flag leaves the source unit's status bit untouched
// R8: handler must also clear the source register separately
// R9: master parity flag sets on source rise only when enabled
// R10: queue level flags follow fifos regardless of enables
// R11: new-entry flag sets only when enabled and an address is posted
// R12: level flags are read only and mirror fifo state
// R13: reset clears all flags except both free-empty flags, which set
// R14: control register at 604 holds one enable per source bit
// R15: writing one to a soft trigger sets its flag; trigger reads zero
// R16: output asserts when any set flag has its enable on
`timescale 1ns/1ps
`default_nettype none
`include "isc_defs.svh"
module isc_collector
   import isc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire isc_req_t    req,
   output logic [31:0]      rdata,
   input  wire logic [31:0] event_in,
   input  wire logic        post_new_entry,
   input  wire isc_queue_t  queue,
   input  wire logic        post_irq_mask_n,
   output logic             irq_out
);
   logic [31:0] flags_q, flags_d;
   logic [31:0] event_q, event_d;
   logic [31:0] ctl_q, ctl_d;
   logic [31:0] rdata_d;
   logic [31:0] rise, set_v, clr_v, lvl, status_v, ctl_view;
   logic        wr_stat, wr_ctl;
   logic        irq_d;

   function automatic logic [31:0] place_levels(input isc_queue_t q);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[`ISC_BIT_OPNE] = q.outbound_post_not_empty;
      v[`ISC_BIT_IFE]  = q.inbound_free_empty;
      v[`ISC_BIT_OFE]  = q.outbound_free_empty;
      v[`ISC_BIT_IPF]  = q.inbound_post_full;
      v[`ISC_BIT_OFF]  = q.outbound_free_full;
      return v;
   endfunction : place_levels

   always_comb begin
      wr_stat = req.wr && (req.addr == `ISC_OFS_STATUS);
      wr_ctl  = req.wr && (req.addr == `ISC_OFS_CONTROL);
      rise    = event_in & ~event_q;                        // [R5]
      set_v   = rise & `ISC_LATCH_MASK;
      set_v[`ISC_BIT_IPN] = post_new_entry & ctl_q[`ISC_BIT_IPN];  // [R11]
      set_v[`ISC_BIT_MDP] = rise[`ISC_BIT_MDP] & ctl_q[`ISC_BIT_MDP]; // [R9]
      if (wr_ctl) begin
         set_v[`ISC_SOFT_LSB +: `ISC_SOFT_W] = set_v[`ISC_SOFT_LSB +: `ISC_SOFT_W]
            | req.wdata[`ISC_SOFT_LSB +: `ISC_SOFT_W];      // [R15]
      end
      clr_v   = wr_stat ? (req.wdata & `ISC_LATCH_MASK) : 32'h0000_0000; // [R6] [R12]
      // set wins over a clear in the same cycle; source bits never touched [R7]
      flags_d = (((flags_q & ~clr_v) | set_v) & `ISC_LATCH_MASK);
      event_d = event_in;
      ctl_d   = ctl_q;
      if (wr_ctl) begin
         ctl_d = req.wdata & `ISC_CTL_WR_MASK;              // [R14]
      end
      lvl      = place_levels(queue);                       // [R10] [R12]
      status_v = flags_q | lvl;                             // [R1] [R2] [R3] [R4]
      ctl_view = ctl_q;
      ctl_view[`ISC_BIT_OPNE] = ~post_irq_mask_n;
      // levels count too, masked by their enables
      irq_d    = |(status_v & ctl_view);                    // [R16]
      rdata_d  = 32'h0000_0000;
      if (req.rd && req.addr == `ISC_OFS_STATUS) begin
         rdata_d = status_v;
      end else if (req.rd && req.addr == `ISC_OFS_CONTROL) begin
         rdata_d = ctl_view;                                // [R15]
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= `ISC_STATUS_RESET & `ISC_LATCH_MASK;    // [R13]
         event_q <= 32'h0000_0000;
         ctl_q   <= `ISC_CONTROL_RESET;
         rdata   <= 32'h0000_0000;
         irq_out <= 1'b0;
      end else begin
         flags_q <= flags_d;
         event_q <= event_d;
         ctl_q   <= ctl_d;
         rdata   <= rdata_d;
         irq_out <= irq_d;                                  // [R16]
      end
   end

   // steps of a clear and of a status read
   sequence s_clear_top;
      wr_stat && req.wdata[31] && !rise[31];
   endsequence

   sequence s_top_gone;
      !flags_q[31];
   endsequence

   sequence s_set_and_clear;
      rise[31] && wr_stat && req.wdata[31];
   endsequence

   sequence s_status_read;
      req.rd && (req.addr == `ISC_OFS_STATUS);
   endsequence

   a_flag_sets: assert property (@(posedge mclk) disable iff (!rstn) // [R5]
      rise[0] |=> flags_q[0])
      else $error("soft flag did not set");

   a_flag_holds: assert property (@(posedge mclk) disable iff (!rstn) // [R6]
      flags_q[31] && !(wr_stat && req.wdata[31]) |=> flags_q[31])
      else $error("flag dropped");

   a_flag_clears: assert property (@(posedge mclk) disable iff (!rstn) // [R6]
      wr_stat && req.wdata[30] && !rise[30] |=> !flags_q[30])
      else $error("flag not cleared");

   a_mdp_gated: assert property (@(posedge mclk) disable iff (!rstn) // [R9]
      !flags_q[29] && !ctl_q[29] |=> !flags_q[29])
      else $error("parity flag set while disabled");

   a_ipn_gated: assert property (@(posedge mclk) disable iff (!rstn) // [R11]
      post_new_entry && ctl_q[12] |=> flags_q[12])
      else $error("new entry missed");

   a_level_ro: assert property (@(posedge mclk) disable iff (!rstn) // [R12]
      (flags_q & `ISC_LEVEL_MASK) == 32'h0000_0000)
      else $error("level bit latched");

   a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn) // [R4]
      flags_q[7:4] == 4'h0)
      else $error("reserved bits set");

   a_soft_trigger: assert property (@(posedge mclk) disable iff (!rstn) // [R15]
      wr_ctl && req.wdata[1] |=> flags_q[1] && !ctl_q[1])
      else $error("soft trigger wrong");

   a_irq_map: assert property (@(posedge mclk) disable iff (!rstn) // [R16]
      |(flags_q & ctl_q) |=> irq_out)
      else $error("irq not asserted");

   a_clear_top: assert property (@(posedge mclk) disable iff (!rstn) // [R6]
      s_clear_top |=> s_top_gone)
      else $error("top flag not cleared");

   a_set_wins: assert property (@(posedge mclk) disable iff (!rstn) // [R5]
      s_set_and_clear |=> flags_q[31])
      else $error("clear beat a new event");

   a_read_status: assert property (@(posedge mclk) disable iff (!rstn) // [R1]
      s_status_read |=> rdata == $past(status_v))
      else $error("status read wrong");

   a_reserved_read: assert property (@(posedge mclk) disable iff (!rstn) // [R4]
      s_status_read |=> rdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

   a_read_control: assert property (@(posedge mclk) disable iff (!rstn) // [R14]
      req.rd && (req.addr == `ISC_OFS_CONTROL) |=> rdata == $past(ctl_view))
      else $error("control read wrong");

   a_read_idle: assert property (@(posedge mclk) disable iff (!rstn) // [R14]
      !req.rd |=> rdata == 32'h0000_0000)
      else $error("read data without a read");

   a_level_live: assert property (@(posedge mclk) disable iff (!rstn) // [R10]
      (status_v & `ISC_LEVEL_MASK) == place_levels(queue))
      else $error("level flag not live");

   a_ctl_soft_zero: assert property (@(posedge mclk) disable iff (!rstn) // [R15]
      ctl_q[`ISC_SOFT_LSB +: `ISC_SOFT_W] == 4'h0)
      else $error("soft trigger stored");

   a_ctl_write: assert property (@(posedge mclk) disable iff (!rstn) // [R14]
      wr_ctl |=> ctl_q == ($past(req.wdata) & `ISC_CTL_WR_MASK))
      else $error("control write lost");

   a_ctl_hold: assert property (@(posedge mclk) disable iff (!rstn) // [R14]
      !wr_ctl |=> $stable(ctl_q))
      else $error("control changed without write");

   a_opne_mirror: assert property (@(posedge mclk) disable iff (!rstn) // [R14]
      ctl_view[`ISC_BIT_OPNE] == !post_irq_mask_n)
      else $error("post enable mirror wrong");

   a_irq_quiet: assert property (@(posedge mclk) disable iff (!rstn) // [R16]
      (status_v & ctl_view) == 32'h0000_0000 |=> !irq_out)
      else $error("irq without enabled flag");

   a_no_spurious: assert property (@(posedge mclk) disable iff (!rstn) // [R5]
      !flags_q[0] && !rise[0] && !(wr_ctl && req.wdata[0]) |=> !flags_q[0])
      else $error("flag set without event");

   a_ipn_off: assert property (@(posedge mclk) disable iff (!rstn) // [R11]
      !flags_q[`ISC_BIT_IPN] && !ctl_q[`ISC_BIT_IPN] |=> !flags_q[`ISC_BIT_IPN])
      else $error("new entry flag set while disabled");

   a_mdp_sets: assert property (@(posedge mclk) disable iff (!rstn) // [R9]
      rise[`ISC_BIT_MDP] && ctl_q[`ISC_BIT_MDP] |=> flags_q[`ISC_BIT_MDP])
      else $error("parity flag missed");

   a_unmapped_read: assert property (@(posedge mclk) disable iff (!rstn) // [R14]
      req.rd && (req.addr != `ISC_OFS_STATUS) && (req.addr != `ISC_OFS_CONTROL) |=> rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
endmodule : isc_collector
`default_nettype wire

/* tb/tb_isc_collector.sv */
// Purpose: self-checking bench for the interrupt status collector
// Assumes: inputs driven at the falling edge of mclk
// Notes:   no random stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_isc_collector;
   import isc_pkg::*;
   logic        mclk = 1'b0, rstn = 1'b0, pne = 1'b0, irq_out;
   isc_req_t    req = '0;
   isc_queue_t  queue = 5'h0C;
   logic [31:0] ev = 32'h0, rdata, got;
   int          mismatches = 0, comparisons = 0;
   always #4 mclk = ~mclk;
   isc_collector uut (.mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .event_in(ev),
      .post_new_entry(pne), .queue(queue), .post_irq_mask_n(1'b1), .irq_out(irq_out));
   task chk(string n, logic [31:0] e, logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task acc(logic w, logic [11:0] a, logic [31:0] d = 32'h0);
      @(negedge mclk);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge mclk);
      req = '0;
      got = rdata;
   endtask : acc
   task pulse(logic [31:0] v, logic p = 1'b0);
      @(negedge mclk);
      ev = v;
      pne = p;
      @(negedge mclk);
      ev = 32'h0;
      pne = 1'b0;
   endtask : pulse
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      #40000;
      mismatches++;
      conclude;
   end
   task test_reset;
      acc(0, 12'h600);
      chk("status", 32'h0000_0C00, got);
      acc(0, 12'h604);
      chk("control", 32'h0, got);
      acc(0, 12'h608);
      chk("unmapped", 32'h0, got);
      $display("reset test done");
   endtask : test_reset
   task test_latch;
      pulse(32'h8001_4009);
      acc(0, 12'h600);
      chk("latched", 32'h8001_4C09, got);
      acc(1, 12'h600, 32'h8000_0001);
      acc(0, 12'h600);
      chk("w1c", 32'h0001_4C08, got);
      acc(1, 12'h604, 32'h0001_0000);
      @(negedge mclk);
      chk("irq on", 32'h1, {31'h0, irq_out});
      acc(1, 12'h600, 32'hFFFF_FFFF);
      @(negedge mclk);
      chk("irq off", 32'h0, {31'h0, irq_out});
      $display("latch test done");
   endtask : test_latch
   task test_queue;
      queue = 5'h13;
      acc(1, 12'h600, 32'hFFFF_FFFF);
      acc(0, 12'h600);
      chk("levels", 32'h0000_2300, got);
      queue = 5'h0C;
      acc(1, 12'h604, 32'h0000_000F);
      acc(0, 12'h604);
      chk("trigger", 32'h0, got);
      pulse(32'h0, 1'b1);
      acc(0, 12'h600);
      chk("soft", 32'h0000_0C0F, got);
      acc(1, 12'h604, 32'h0000_1000);
      pulse(32'h0, 1'b1);
      acc(0, 12'h600);
      chk("new entry", 32'h0000_1C0F, got);
      $display("queue test done");
   endtask : test_queue
   task test_source;
      acc(1, 12'h600, 32'hFFFF_FFFF);
      pulse(32'h2000_0000);
      acc(0, 12'h600);
      chk("parity gated", 32'h0000_0C00, got);
      acc(1, 12'h604, 32'h2000_0000);
      @(negedge mclk);
      ev = 32'h6000_0000;
      acc(0, 12'h600);
      chk("source held", 32'h6000_0C00, got);
      acc(1, 12'h600, 32'h6000_0000);
      acc(0, 12'h600);
      chk("flag only", 32'h0000_0C00, got);
      ev = 32'h0;
      pulse(32'h6000_0000);
      acc(0, 12'h600);
      chk("re-armed", 32'h6000_0C00, got);
      $display("source test done");
   endtask : test_source
   initial begin
      repeat (8) @(posedge mclk);
      @(negedge mclk) rstn = 1'b1;
      test_reset;
      test_latch;
      test_queue;
      test_source;
      conclude;
   end
endmodule : tb_isc_collector
`default_nettype wire
